// File: rtl/pmc_pkg.sv
// package of constants and types for the power mode controller
// Function
// - five modes, run down to shutdown, decreasing power
// - processor executes only while in run
// - peripheral interrupt wakes sleep, stop, standby
// - shutdown turns the core regulator fully off
// - shutdown wakes on reset pin, debug, io
// - each active mode offers selectable policy sub-options
// - processor and memories in high-performance domain
// - high-performance domain on only in run, sleep and the wake settle state
// - low-power domain on in run through standby
// - shutdown disables both power domains
// - powered-off configuration is lost, rewritten after wake
package pmc_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_MODE_REQ = 8'h00;
  localparam logic [7:0] OFS_POLICY = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_WAKE_CFG = 8'h14;

  // mode request codes written to the mode request register
  localparam logic [2:0] REQ_RUN = 3'h0;
  localparam logic [2:0] REQ_SLEEP = 3'h1;
  localparam logic [2:0] REQ_STOP = 3'h2;
  localparam logic [2:0] REQ_STANDBY = 3'h3;
  localparam logic [2:0] REQ_SHUTDOWN = 3'h4;

  // policy register: one two-bit field per mode, run through standby
  localparam int POL_RUN_LSB = 0;
  localparam int POL_SLEEP_LSB = 2;
  localparam int POL_STOP_LSB = 4;
  localparam int POL_STBY_LSB = 6;
  localparam logic [1:0] POL_MAX_3 = 2'h2;
  localparam logic [1:0] POL_MAX_STBY = 2'h1;
  localparam logic [7:0] POLICY_RST = 8'h00;

  // interrupt status and mask bits
  localparam int IRQ_W = 3;
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_REFUSED = 1;
  localparam int IRQ_SD_WAKE = 2;
  localparam logic [2:0] IRQ_RST = 3'h0;

  // status register layout
  localparam int ST_MODE_LSB = 0;
  localparam int ST_CPU = 8;
  localparam int ST_HP = 9;
  localparam int ST_LP = 10;
  localparam int ST_REG = 11;
  localparam int ST_POL_LSB = 12;

  // wake configuration: io enable in low byte, io level in next byte
  localparam int WCFG_EN_LSB = 0;
  localparam int WCFG_LVL_LSB = 8;
  localparam logic [15:0] WAKE_CFG_RST = 16'h0000;

  // timing: settle time for the high-performance domain on wake
  localparam int CLK_PERIOD_NS = 40;
  localparam int WAKE_SETTLE_NS = 200;
  localparam int WAKE_SETTLE_CYC = (WAKE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] WAKE_CNT_INIT = 4'(WAKE_SETTLE_CYC - 1);

  typedef enum logic [5:0] {
    PMC_RUN = 6'h01,
    PMC_SLEEP = 6'h02,
    PMC_STOP = 6'h04,
    PMC_STANDBY = 6'h08,
    PMC_SHUTDOWN = 6'h10,
    PMC_WAKE = 6'h20
  } pmc_state_t;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } pmc_bus_t;

  // power enables toward the supply network
  typedef struct packed {
    logic core_reg_en;
    logic hp_pwr_en;
    logic lp_pwr_en;
    logic cpu_run_en;
  } pmc_pwr_t;

endpackage : pmc_pkg

// File: rtl/pmc_wake_det.sv
// wake source detector for the power mode controller
`timescale 1ns/1ns
module pmc_wake_det #(
  parameter int IRQ_N = 8,
  parameter int IO_W = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [IRQ_N-1:0] periph_irq,
  input wire logic swd_active,
  input wire logic [IO_W-1:0] io_in,
  input wire logic [IO_W-1:0] io_wake_en,
  input wire logic [IO_W-1:0] io_wake_lvl,
  output logic periph_wake,
  output logic sd_wake
);

  logic [IO_W-1:0] io_match;

  // per pin level compare, only enabled pins can match
  genvar gi;
  generate
    for (gi = 0; gi < IO_W; gi++) begin : g_io
      assign io_match[gi] = io_wake_en[gi] & ~(io_in[gi] ^ io_wake_lvl[gi]);
    end
  endgenerate

  // any peripheral interrupt line wakes the low modes
  always_ff @(posedge mclk) begin
    if (rst) begin
      periph_wake <= 1'b0;
    end else begin
      periph_wake <= |periph_irq;
    end
  end

  // shutdown wake: debug activity or io level match only
  always_ff @(posedge mclk) begin
    if (rst) begin
      sd_wake <= 1'b0;
    end else begin
      sd_wake <= swd_active | (|io_match);
    end
  end

endmodule : pmc_wake_det

// File: rtl/pmc_ctrl.sv
// power mode controller: mode sequencer, domain enables and registers
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ns
module pmc_ctrl #(
  parameter int IRQ_N = 8,
  parameter int IO_W = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire pmc_pkg::pmc_bus_t bus_req,
  output logic [31:0] rdata,
  input wire logic [IRQ_N-1:0] periph_irq,
  input wire logic swd_active,
  input wire logic external_reset_pin_n,
  input wire logic [IO_W-1:0] io_in,
  output pmc_pkg::pmc_pwr_t pwr,
  output logic [5:0] mode_state,
  output logic [1:0] policy_sel,
  output logic irq
);

  pmc_pkg::pmc_state_t state_q;
  pmc_pkg::pmc_state_t state_d;
  logic [3:0] wake_cnt_q;
  logic [7:0] policy_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_mask_q;
  logic [15:0] wake_cfg_q;
  logic [31:0] rdata_q;
  logic sd_wake_q;
  logic sd_wake_seen_q;
  logic core_rst;
  logic periph_wake;
  logic sd_wake;
  logic wr_mode;
  logic mode_ok;
  logic refused;
  logic woke;
  logic [2:0] irq_set;
  pmc_pkg::pmc_pwr_t pwr_d;
  logic [1:0] pol_d;

  // clamp a policy field to the highest sub-option a mode offers
  function automatic logic [1:0] pol_clamp(input logic [1:0] v, input logic [1:0] maxv);
    pol_clamp = (v > maxv) ? maxv : v;
  endfunction : pol_clamp

  // register port decode, used for writes; reads decode the address in a case
  function automatic logic hit(input pmc_pkg::pmc_bus_t b, input logic [7:0] ofs);
    hit = (b.addr == ofs);
  endfunction : hit

  // core reset covers power-on reset, the reset pin and a shutdown wake,
  // so the regulator coming back up always looks like a fresh start
  assign core_rst = rst | ~external_reset_pin_n | sd_wake_q;

  pmc_wake_det #(
    .IRQ_N(IRQ_N),
    .IO_W(IO_W)
  ) u_wake (
    .mclk(mclk),
    .rst(rst),
    .periph_irq(periph_irq),
    .swd_active(swd_active),
    .io_in(io_in),
    .io_wake_en(wake_cfg_q[pmc_pkg::WCFG_EN_LSB +: IO_W]),
    .io_wake_lvl(wake_cfg_q[pmc_pkg::WCFG_LVL_LSB +: IO_W]),
    .periph_wake(periph_wake),
    .sd_wake(sd_wake)
  );

  // mode request decode; codes above shutdown are refused
  // a write of the run code while in run is accepted and changes nothing
  assign wr_mode = bus_req.wr & hit(bus_req, pmc_pkg::OFS_MODE_REQ);
  assign mode_ok = bus_req.wdata[2:0] <= pmc_pkg::REQ_SHUTDOWN;
  // a request outside run cannot come from code, so it is refused too
  assign refused = wr_mode & (~mode_ok | (state_q != pmc_pkg::PMC_RUN));
  assign woke = (state_d == pmc_pkg::PMC_RUN) & (state_q != pmc_pkg::PMC_RUN);

  // next-state logic of the mode sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      pmc_pkg::PMC_RUN: begin
        if (wr_mode & mode_ok) begin
          case (bus_req.wdata[2:0])
            pmc_pkg::REQ_SLEEP: state_d = pmc_pkg::PMC_SLEEP;
            pmc_pkg::REQ_STOP: state_d = pmc_pkg::PMC_STOP;
            pmc_pkg::REQ_STANDBY: state_d = pmc_pkg::PMC_STANDBY;
            pmc_pkg::REQ_SHUTDOWN: state_d = pmc_pkg::PMC_SHUTDOWN;
            default: state_d = pmc_pkg::PMC_RUN;
          endcase
        end
      end
      pmc_pkg::PMC_SLEEP: begin
        // high-performance domain stayed up, so return at once
        if (periph_wake) begin
          state_d = pmc_pkg::PMC_RUN;
        end
      end
      pmc_pkg::PMC_STOP, pmc_pkg::PMC_STANDBY: begin
        // domain was off: let it settle before the processor runs
        if (periph_wake) begin
          state_d = pmc_pkg::PMC_WAKE;
        end
      end
      pmc_pkg::PMC_WAKE: begin
        if (wake_cnt_q == 4'h0) begin
          state_d = pmc_pkg::PMC_RUN;
        end
      end
      pmc_pkg::PMC_SHUTDOWN: begin
        // peripheral interrupts are ignored here; only a core reset leaves
        state_d = pmc_pkg::PMC_SHUTDOWN;
      end
      default: state_d = pmc_pkg::PMC_RUN;
    endcase
  end

  // mode state register; every reset lands in run
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      state_q <= pmc_pkg::PMC_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // settle counter, loaded when a deep-mode wake starts
  // only four bits wide: a settle time beyond sixteen cycles needs a wider
  // counter and a wider load value
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      wake_cnt_q <= 4'h0;
    end else if (state_q != pmc_pkg::PMC_WAKE) begin
      wake_cnt_q <= pmc_pkg::WAKE_CNT_INIT;
    end else if (wake_cnt_q != 4'h0) begin
      wake_cnt_q <= wake_cnt_q - 4'h1;
    end
  end

  // shutdown wake pulse: one cycle of core reset, then a cause flag
  // the pulse clears itself, so a wake source held high cannot keep
  // the core in reset once run is entered
  always_ff @(posedge mclk) begin
    if (rst) begin
      sd_wake_q <= 1'b0;
      sd_wake_seen_q <= 1'b0;
    end else begin
      sd_wake_q <= (state_q == pmc_pkg::PMC_SHUTDOWN) & sd_wake & ~sd_wake_q;
      sd_wake_seen_q <= sd_wake_q;
    end
  end

  // power enables per mode
  // registered below, so supplies switch one cycle after the state
  always_comb begin
    pwr_d = '0;
    case (state_q)
      pmc_pkg::PMC_RUN: begin
        pwr_d.core_reg_en = 1'b1;
        pwr_d.hp_pwr_en = 1'b1;
        pwr_d.lp_pwr_en = 1'b1;
        pwr_d.cpu_run_en = 1'b1;
      end
      pmc_pkg::PMC_SLEEP: begin
        pwr_d.core_reg_en = 1'b1;
        pwr_d.hp_pwr_en = 1'b1;
        pwr_d.lp_pwr_en = 1'b1;
      end
      pmc_pkg::PMC_STOP, pmc_pkg::PMC_STANDBY: begin
        pwr_d.core_reg_en = 1'b1;
        pwr_d.lp_pwr_en = 1'b1;
      end
      pmc_pkg::PMC_WAKE: begin
        // domain ramps up while the processor is still held
        pwr_d.core_reg_en = 1'b1;
        pwr_d.hp_pwr_en = 1'b1;
        pwr_d.lp_pwr_en = 1'b1;
      end
      pmc_pkg::PMC_SHUTDOWN: begin
        pwr_d = '0;
      end
      default: pwr_d = '0;
    endcase
  end

  // policy sub-option of the present mode, clamped to what it offers
  always_comb begin
    pol_d = 2'h0;
    case (state_q)
      pmc_pkg::PMC_RUN, pmc_pkg::PMC_WAKE: begin
        pol_d = pol_clamp(policy_q[pmc_pkg::POL_RUN_LSB +: 2], pmc_pkg::POL_MAX_3);
      end
      pmc_pkg::PMC_SLEEP: begin
        pol_d = pol_clamp(policy_q[pmc_pkg::POL_SLEEP_LSB +: 2], pmc_pkg::POL_MAX_3);
      end
      pmc_pkg::PMC_STOP: begin
        pol_d = pol_clamp(policy_q[pmc_pkg::POL_STOP_LSB +: 2], pmc_pkg::POL_MAX_3);
      end
      pmc_pkg::PMC_STANDBY: begin
        pol_d = pol_clamp(policy_q[pmc_pkg::POL_STBY_LSB +: 2], pmc_pkg::POL_MAX_STBY);
      end
      default: pol_d = 2'h0;
    endcase
  end

  // registered outputs toward the supply network
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      pwr <= '0;
      mode_state <= 6'h00;
      policy_sel <= 2'h0;
    end else begin
      pwr <= pwr_d;
      mode_state <= state_q;
      policy_sel <= pol_d;
    end
  end

  // policy register; lost on shutdown since the core reset clears it
  // it keeps the raw value written; only the applied selection is clamped
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      policy_q <= pmc_pkg::POLICY_RST;
    end else if (bus_req.wr & hit(bus_req, pmc_pkg::OFS_POLICY)) begin
      policy_q <= bus_req.wdata[7:0];
    end
  end

  // wake configuration sits in the always-on part: power-on reset only,
  // otherwise the io match could never be armed across shutdown
  always_ff @(posedge mclk) begin
    if (rst) begin
      wake_cfg_q <= pmc_pkg::WAKE_CFG_RST;
    end else if (bus_req.wr & hit(bus_req, pmc_pkg::OFS_WAKE_CFG)) begin
      wake_cfg_q <= bus_req.wdata[15:0];
    end
  end

  // interrupt mask, cleared with the rest of the core state
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      irq_mask_q <= pmc_pkg::IRQ_RST;
    end else if (bus_req.wr & hit(bus_req, pmc_pkg::OFS_IRQ_MASK)) begin
      irq_mask_q <= bus_req.wdata[2:0];
    end
  end

  // event sources for the sticky status bits
  always_comb begin
    irq_set = 3'h0;
    irq_set[pmc_pkg::IRQ_WAKE] = woke;
    irq_set[pmc_pkg::IRQ_REFUSED] = refused;
    irq_set[pmc_pkg::IRQ_SD_WAKE] = sd_wake_seen_q;
  end

  // sticky status, write one to clear; a set in the same cycle wins
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      irq_stat_q <= pmc_pkg::IRQ_RST;
    end else if (bus_req.wr & hit(bus_req, pmc_pkg::OFS_IRQ_STAT)) begin
      irq_stat_q <= (irq_stat_q & ~bus_req.wdata[2:0]) | irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  // level interrupt, high while any unmasked status bit is set
  // combinational so a clear is seen at once, at the cost of a gate path
  assign irq = |(irq_stat_q & irq_mask_q);

  // read data register: valid the cycle after the read strobe only
  // status shows the present state, one cycle ahead of mode_state
  always_ff @(posedge mclk) begin
    if (core_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (!bus_req.rd) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      case (bus_req.addr)
        pmc_pkg::OFS_MODE_REQ: rdata_q <= 32'h0000_0000;
        pmc_pkg::OFS_POLICY: rdata_q <= {24'h00_0000, policy_q};
        pmc_pkg::OFS_STATUS: begin
          rdata_q <= 32'h0000_0000;
          rdata_q[pmc_pkg::ST_MODE_LSB +: 6] <= state_q;
          rdata_q[pmc_pkg::ST_CPU] <= pwr_d.cpu_run_en;
          rdata_q[pmc_pkg::ST_HP] <= pwr_d.hp_pwr_en;
          rdata_q[pmc_pkg::ST_LP] <= pwr_d.lp_pwr_en;
          rdata_q[pmc_pkg::ST_REG] <= pwr_d.core_reg_en;
          rdata_q[pmc_pkg::ST_POL_LSB +: 2] <= pol_d;
        end
        pmc_pkg::OFS_IRQ_STAT: rdata_q <= {29'h0000_0000, irq_stat_q};
        pmc_pkg::OFS_IRQ_MASK: rdata_q <= {29'h0000_0000, irq_mask_q};
        pmc_pkg::OFS_WAKE_CFG: rdata_q <= {16'h0000, wake_cfg_q};
        default: rdata_q <= 32'h0000_0000; // unmapped reads as zero
      endcase
    end
  end

  assign rdata = rdata_q;

endmodule : pmc_ctrl

// File: testbench/pmc_ctrl_chk.sv
// checker for the power mode controller ports
`timescale 1ns/1ns
module pmc_ctrl_chk #(
  parameter int IRQ_N = 8,
  parameter int IO_W = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire pmc_pkg::pmc_bus_t bus_req,
  input wire logic [31:0] rdata,
  input wire logic [IRQ_N-1:0] periph_irq,
  input wire logic swd_active,
  input wire logic external_reset_pin_n,
  input wire logic [IO_W-1:0] io_in,
  input wire pmc_pkg::pmc_pwr_t pwr,
  input wire logic [5:0] mode_state,
  input wire logic [1:0] policy_sel,
  input wire logic irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // enables and mode_state are both one edge behind the state, so they compare directly
  property p_cpu_run;
    pwr.cpu_run_en == (mode_state == 6'h01);
  endproperty
  a_cpu_run: assert property (p_cpu_run)
    else $error("cpu enable differs from run state");
  property p_hp_dom;
    pwr.hp_pwr_en == (mode_state inside {6'h01, 6'h02, 6'h20});
  endproperty
  a_hp_dom: assert property (p_hp_dom)
    else $error("high performance domain enable wrong for mode");
  property p_lp_dom;
    (mode_state inside {6'h01, 6'h02, 6'h04, 6'h08}) |-> pwr.lp_pwr_en;
  endproperty
  a_lp_dom: assert property (p_lp_dom)
    else $error("low power domain off in an active mode");
  property p_sd_off;
    mode_state == 6'h10 |-> pwr == '0;
  endproperty
  a_sd_off: assert property (p_sd_off)
    else $error("supply left on in shutdown");
  // sleep returns straight to run, stop and standby go through the settle state
  property p_sleep_wake;
    mode_state == 6'h02 && periph_irq != '0 |-> ##[1:5] mode_state == 6'h01;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake)
    else $error("no return to run from sleep");
  property p_stop_wake;
    (mode_state inside {6'h04, 6'h08}) && periph_irq != '0 |-> ##[1:10] mode_state == 6'h01;
  endproperty
  a_stop_wake: assert property (p_stop_wake)
    else $error("no return to run from stop or standby");
  property p_sd_wake;
    mode_state == 6'h10 && swd_active |-> ##[1:8] mode_state == 6'h01;
  endproperty
  a_sd_wake: assert property (p_sd_wake)
    else $error("debug activity did not wake from shutdown");
  // reset checks must see the reset itself, so they are never disabled
  property p_rst_clear;
    disable iff (1'b0) rst |=> mode_state == 6'h00 && pwr == '0;
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("outputs not cleared in reset");
  property p_rst_run;
    disable iff (1'b0) rst ##1 !rst |-> ##1 mode_state == 6'h01 && pwr == 4'hf;
  endproperty
  a_rst_run: assert property (p_rst_run)
    else $error("run not entered after reset");

  c_sleep: cover property (mode_state == 6'h02);
  c_settle: cover property (mode_state == 6'h20);
  c_sd_exit: cover property (mode_state == 6'h10 ##1 mode_state == 6'h00);
endmodule : pmc_ctrl_chk

bind pmc_ctrl pmc_ctrl_chk #(.IRQ_N(IRQ_N), .IO_W(IO_W)) i_chk (
  .mclk(mclk), .rst(rst), .bus_req(bus_req), .rdata(rdata), .periph_irq(periph_irq),
  .swd_active(swd_active), .external_reset_pin_n(external_reset_pin_n), .io_in(io_in),
  .pwr(pwr), .mode_state(mode_state), .policy_sel(policy_sel), .irq(irq)
);

// File: testbench/tb.sv
// self-checking testbench for the power mode controller
`timescale 1ns/1ns
module tb;
  typedef struct packed {
    logic [2:0] code;
    logic [5:0] ms;
    logic [2:0] pw;
    logic sd;
    logic [2:0] st;
  } pmc_row_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  pmc_pkg::pmc_bus_t bus_req = '0;
  logic [31:0] rdata;
  logic [7:0] periph_irq = '0;
  logic swd_active = 1'b0;
  logic external_reset_pin_n = 1'b1;
  logic [7:0] io_in = '0;
  pmc_pkg::pmc_pwr_t pwr;
  logic [5:0] mode_state;
  logic [1:0] policy_sel;
  logic irq;
  int n_errors = 0;
  int tests_run = 0;
  // pw is {hp, lp, cpu}; st is the status expected after the wake
  pmc_row_t rows [4] = '{
    '{pmc_pkg::REQ_SLEEP, 6'h02, 3'h6, 1'b0, 3'h1},
    '{pmc_pkg::REQ_STOP, 6'h04, 3'h2, 1'b0, 3'h1},
    '{pmc_pkg::REQ_STANDBY, 6'h08, 3'h2, 1'b0, 3'h1},
    '{pmc_pkg::REQ_SHUTDOWN, 6'h10, 3'h0, 1'b1, 3'h4}};

  pmc_ctrl #(.IRQ_N(8), .IO_W(8)) i_dut (
    .mclk(mclk), .rst(rst), .bus_req(bus_req), .rdata(rdata), .periph_irq(periph_irq),
    .swd_active(swd_active), .external_reset_pin_n(external_reset_pin_n), .io_in(io_in),
    .pwr(pwr), .mode_state(mode_state), .policy_sel(policy_sel), .irq(irq)
  );

  always #20 mclk = ~mclk;

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    bus_req <= '0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge mclk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge mclk);
    bus_req <= '0;
    #1 chk(nm, e, rdata);
  endtask : rd

  // bounded wait; a hang ends the run through the closing report
  task automatic wait_ms(input logic [5:0] e, input int n);
    int i;
    i = 0;
    while (mode_state !== e && i < n) begin
      @(posedge mclk);
      #1;
      i++;
    end
    if (mode_state !== e) begin
      n_errors++;
      $display("[FAIL] mode wait expected %h seen %h", e, mode_state);
      report_and_stop();
    end
  endtask : wait_ms

  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1 chk("mode after reset", 32'h01, mode_state);
    chk("pwr after reset", 32'hf, pwr);
    rd(pmc_pkg::OFS_POLICY, 32'h0, "policy reset");
    rd(pmc_pkg::OFS_IRQ_MASK, 32'h0, "mask reset");
    rd(8'h18, 32'h0, "unmapped read");
    $display("test reset done");
    // each row enters a mode, checks the enables and wakes back to run
    foreach (rows[k]) begin
      wr(pmc_pkg::OFS_MODE_REQ, {29'h0, rows[k].code});
      wait_ms(rows[k].ms, 4);
      chk("domain enables", {29'h0, rows[k].pw}, {29'h0, pwr[2:0]});
      @(posedge mclk);
      if (rows[k].sd) swd_active <= 1'b1;
      else periph_irq <= 8'h80;
      wait_ms(6'h01, 20);
      @(posedge mclk);
      swd_active <= 1'b0;
      periph_irq <= '0;
      rd(pmc_pkg::OFS_IRQ_STAT, {29'h0, rows[k].st}, "wake status");
      wr(pmc_pkg::OFS_IRQ_STAT, 32'h7);
      $display("test row %0d done", k);
    end
    // an illegal code is refused and raises a maskable event
    wr(pmc_pkg::OFS_MODE_REQ, 32'h5);
    #1 chk("mode after bad code", 32'h01, mode_state);
    rd(pmc_pkg::OFS_IRQ_STAT, 32'h2, "refused status");
    chk("irq masked", 32'h0, irq);
    wr(pmc_pkg::OFS_IRQ_MASK, 32'h2);
    #1 chk("irq unmasked", 32'h1, irq);
    wr(pmc_pkg::OFS_IRQ_STAT, 32'h2);
    #1 chk("irq cleared", 32'h0, irq);
    $display("test refusal done");
    // the run policy clamps; shutdown ignores peripherals, wakes on io, loses the policy and keeps wake config
    wr(pmc_pkg::OFS_POLICY, 32'hff);
    // the register keeps the raw value; only the applied selection is clamped
    rd(pmc_pkg::OFS_POLICY, 32'hff, "policy raw");
    chk("run policy", 32'h2, policy_sel);
    // run state, all four enables on, clamped run policy of two
    rd(pmc_pkg::OFS_STATUS, 32'h0000_2f01, "status in run");
    wr(pmc_pkg::OFS_WAKE_CFG, 32'h0101);
    wr(pmc_pkg::OFS_MODE_REQ, {29'h0, pmc_pkg::REQ_SHUTDOWN});
    wait_ms(6'h10, 4);
    chk("regulator off", 32'h0, pwr);
    @(posedge mclk);
    periph_irq <= 8'h01;
    repeat (10) @(posedge mclk);
    #1 chk("shutdown holds", 32'h10, mode_state);
    @(posedge mclk);
    periph_irq <= '0;
    io_in <= 8'h01;
    wait_ms(6'h01, 20);
    @(posedge mclk);
    io_in <= '0;
    rd(pmc_pkg::OFS_POLICY, 32'h0, "policy lost");
    rd(pmc_pkg::OFS_WAKE_CFG, 32'h0101, "wake cfg kept");
    $display("test io wake done");
    // the reset pin forces sleep back to run
    wr(pmc_pkg::OFS_MODE_REQ, {29'h0, pmc_pkg::REQ_SLEEP});
    wait_ms(6'h02, 4);
    // no code runs outside run, so a mode write in sleep is refused
    wr(pmc_pkg::OFS_MODE_REQ, {29'h0, pmc_pkg::REQ_STOP});
    #1 chk("sleep holds", 32'h02, mode_state);
    rd(pmc_pkg::OFS_IRQ_STAT, 32'h6, "refused in sleep");
    @(posedge mclk);
    external_reset_pin_n <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk("mode in pin reset", 32'h0, mode_state);
    @(posedge mclk);
    external_reset_pin_n <= 1'b1;
    wait_ms(6'h01, 4);
    $display("test pin reset done");
    report_and_stop();
  end
endmodule : tb
